// ===== include/asr_pkg.sv
// Constants shared by the serial readout and configuration logic
package asr_pkg;
    // Result word
    localparam int RESULT_BITS = 16;
    localparam int BIT_CNT_W = 5;
    localparam logic [BIT_CNT_W-1:0] BIT_CNT_SAT = 5'h10;
    // Configuration word layout
    localparam int CFG_BITS = 9;
    localparam int CFG_CNT_W = 4;
    localparam logic [CFG_CNT_W-1:0] CFG_LAST_EDGE = 4'h8;
    localparam int CFG_POS_START = 8;
    localparam int CFG_POS_SIGNED = 7;
    localparam int CFG_POS_WIDE = 6;
    localparam int CFG_POS_PDOWN = 5;
    localparam int CFG_POS_CODING = 2;
    localparam logic [CFG_BITS-1:0] CFG_WRITE_MASK = 9'h1e4;
    localparam logic [CFG_BITS-1:0] CFG_RESET = 9'h000;
    // Synchroniser depth
    localparam int SYNC_STAGES = 2;
    // Configuration loader states
    typedef enum logic [1:0]
    {
        ASR_CFG_IDLE = 2'b00,
        ASR_CFG_LOAD = 2'b01,
        ASR_CFG_SKIP = 2'b10
    } asr_cfg_state_t;
endpackage

// ===== core/asr_cfg_port.sv
// Write-only serial configuration port loader
`timescale 1ns/10ps
`default_nettype none
module asr_cfg_port
    import asr_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Mode
    input wire logic port_en,
    input wire logic clk_inv,
    // Synchronised port pins
    input wire logic cfg_clk_s,
    input wire logic cfg_sel_n_s,
    input wire logic cfg_din_s,
    // Applied word
    output logic [CFG_BITS-1:0] cfg_word_q
);
    asr_cfg_state_t state_q;
    logic clk_prev_q;
    logic [CFG_BITS-2:0] shift_q;
    logic [CFG_CNT_W-1:0] edge_cnt_q;
    logic active_edge;
    logic [CFG_BITS-1:0] full_word;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            clk_prev_q <= 1'b0;
        else
            clk_prev_q <= cfg_clk_s;
    end

    // Sampling edge follows the inversion setting
    assign active_edge = clk_inv ? (clk_prev_q & ~cfg_clk_s) : (~clk_prev_q & cfg_clk_s);
    assign full_word = {shift_q, cfg_din_s};

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_q <= ASR_CFG_IDLE;
            edge_cnt_q <= '0;
            shift_q <= '0;
        end
        else if (!port_en || cfg_sel_n_s)
        begin
            state_q <= ASR_CFG_IDLE;
            edge_cnt_q <= '0;
        end
        else if (active_edge)
        begin
            unique case (state_q)
                ASR_CFG_IDLE:
                begin
                    state_q <= cfg_din_s ? ASR_CFG_LOAD : ASR_CFG_SKIP;
                    shift_q <= {{(CFG_BITS-2){1'b0}}, cfg_din_s};
                    edge_cnt_q <= {{(CFG_CNT_W-1){1'b0}}, 1'b1};
                end
                ASR_CFG_LOAD:
                begin
                    shift_q <= full_word[CFG_BITS-2:0];
                    edge_cnt_q <= edge_cnt_q + 4'h1;
                    if (edge_cnt_q == CFG_LAST_EDGE)
                        state_q <= ASR_CFG_SKIP;
                end
                ASR_CFG_SKIP:
                begin
                    state_q <= ASR_CFG_SKIP;
                end
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            cfg_word_q <= CFG_RESET;
        else if (port_en && !cfg_sel_n_s && active_edge && state_q == ASR_CFG_LOAD
                 && edge_cnt_q == CFG_LAST_EDGE)
            cfg_word_q <= (full_word & CFG_WRITE_MASK) | (cfg_word_q & ~CFG_WRITE_MASK);
    end
endmodule
`default_nettype wire

// ===== core/asr_serial_core.sv
// Slave serial result readout, daisy chain and configuration selection
//
// Behaviour
// - After its own 16 bits, the output passes on bits from the chain input.
// - Chain input sampled on the edge opposite the one that advances the output.
// - During conversion with select and read low, previous result shifts out MSB first.
// - Reading not finished before conversion end pulses the overrun flag.
// - Pins give range, coding and power-down in parallel or serial hardware mode.
// - In software configuration mode the configuration pins are ignored.
// - Configuration port works only in serial mode with software select low.
// - Port select low, data shifted MSB first on the chosen clock edge.
// - High start bit on the first sampling edge begins loading a word.
// - Nine-bit word led by start bit; settings applied on the ninth edge.
// - Reserved positions keep their value; only active positions are written.
// - Reset clears the whole configuration word to zero.
// - Positions 7 and 6 choose one of four input ranges.
// - Position 5 high powers down; a later word with it low restores.
// - Position 2 clear gives twos complement, set gives offset binary.
// - Serial interface is used only while serial/parallel select is high.
// - Shift clock is gated by chip select; data driven only in a read frame.
`timescale 1ns/10ps
`default_nettype none
module asr_serial_core
    import asr_pkg::*;
(
    // System clock and reset
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    // Conversion core
    input wire logic CONV_BUSY,
    input wire logic CONV_RESULT_VALID,
    input wire logic [RESULT_BITS-1:0] CONV_RESULT,
    // Serial result link
    input wire logic SERIAL_SHIFT_CLOCK,
    input wire logic CHIP_SELECT_N,
    input wire logic READ_STROBE_N,
    input wire logic CHAIN_SERIAL_INPUT,
    input wire logic SHIFT_CLOCK_INVERT,
    output logic SERIAL_RESULT_OUT,
    output logic SERIAL_RESULT_OE,
    output logic READ_OVERRUN_FLAG,
    // Mode pins
    input wire logic SERIAL_PARALLEL_SEL,
    input wire logic CLOCK_SOURCE_SEL,
    input wire logic HARDWARE_SOFTWARE_SEL,
    // Hardware configuration pins
    input wire logic RANGE_SIGNED_PIN,
    input wire logic WIDE_RANGE_SEL,
    input wire logic POWER_DOWN_PIN,
    input wire logic OUTPUT_CODING_SEL,
    // Configuration port
    input wire logic CONFIG_PORT_CLOCK,
    input wire logic CONFIG_PORT_SELECT_N,
    input wire logic CONFIG_PORT_DATA_IN,
    // Applied configuration
    output logic RANGE_SIGNED,
    output logic RANGE_WIDE,
    output logic POWER_DOWN,
    output logic OFFSET_BINARY,
    output logic [CFG_BITS-1:0] CONFIG_WORD
);
    // ------------------------------------------------------------------
    // Link domain: shift clock, framed by chip select and read strobe
    // ------------------------------------------------------------------
    logic shift_clk_eff;
    logic frame_idle;
    logic [BIT_CNT_W-1:0] bit_cnt_q;
    logic [RESULT_BITS-2:0] chain_dly_q;
    logic [RESULT_BITS-1:0] out_word_q;
    logic [BIT_CNT_W-1:0] bit_sel;
    logic serial_bit;
    logic chain_out_q;

    // Inversion swaps which edge launches and which samples
    assign shift_clk_eff = SERIAL_SHIFT_CLOCK ^ SHIFT_CLOCK_INVERT;

    // The frame's own signal ends all link-side state
    assign frame_idle = CHIP_SELECT_N | READ_STROBE_N;

    // Launch edge advances the bit position; saturates once chaining starts
    always_ff @(posedge shift_clk_eff or posedge frame_idle)
    begin
        if (frame_idle)
            bit_cnt_q <= '0;
        else if (bit_cnt_q != BIT_CNT_SAT)
            bit_cnt_q <= bit_cnt_q + 5'h01;
    end

    // Chain input sampled on the opposite edge
    always_ff @(negedge shift_clk_eff or posedge frame_idle)
    begin
        if (frame_idle)
            chain_dly_q <= '0;
        else
            chain_dly_q <= {chain_dly_q[RESULT_BITS-3:0], CHAIN_SERIAL_INPUT};
    end

    // Upstream bit moves out on the launch edge so it stands a full cycle
    always_ff @(posedge shift_clk_eff or posedge frame_idle)
    begin
        if (frame_idle)
            chain_out_q <= 1'b0;
        else
            chain_out_q <= chain_dly_q[RESULT_BITS-2];
    end

    assign bit_sel = BIT_CNT_SAT - 5'h01 - bit_cnt_q;

    // Own result MSB first, then the upstream bits one cycle after the LSB
    always_comb
    begin
        if (bit_cnt_q < BIT_CNT_SAT)
            serial_bit = out_word_q[bit_sel[BIT_CNT_W-2:0]];
        else
            serial_bit = chain_out_q;
    end

    // ------------------------------------------------------------------
    // System domain synchronisers
    // ------------------------------------------------------------------
    logic [SYNC_STAGES-1:0] frame_sync_q;
    logic [SYNC_STAGES-1:0] done_sync_q;
    logic [SYNC_STAGES-1:0] ser_sync_q;
    logic [SYNC_STAGES-1:0] ext_sync_q;
    logic [SYNC_STAGES-1:0] hwsw_sync_q;
    logic [SYNC_STAGES-1:0] inv_sync_q;
    logic [SYNC_STAGES-1:0] pin_signed_sync_q;
    logic [SYNC_STAGES-1:0] pin_wide_sync_q;
    logic [SYNC_STAGES-1:0] pin_pdown_sync_q;
    logic [SYNC_STAGES-1:0] pin_coding_sync_q;
    logic [SYNC_STAGES-1:0] cfg_clk_sync_q;
    logic [SYNC_STAGES-1:0] cfg_sel_sync_q;
    logic [SYNC_STAGES-1:0] cfg_din_sync_q;
    logic frame_s;
    logic done_s;
    logic ser_s;
    logic ext_s;
    logic hwsw_s;

    always_ff @(posedge SYS_CLK)
    begin
        if (!RESET_N)
        begin
            frame_sync_q <= '0;
            done_sync_q <= '0;
        end
        else
        begin
            frame_sync_q <= {frame_sync_q[0], ~frame_idle};
            done_sync_q <= {done_sync_q[0], (bit_cnt_q == BIT_CNT_SAT)};
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (!RESET_N)
        begin
            ser_sync_q <= '0;
            ext_sync_q <= '0;
            hwsw_sync_q <= '0;
            inv_sync_q <= '0;
        end
        else
        begin
            ser_sync_q <= {ser_sync_q[0], SERIAL_PARALLEL_SEL};
            ext_sync_q <= {ext_sync_q[0], CLOCK_SOURCE_SEL};
            hwsw_sync_q <= {hwsw_sync_q[0], HARDWARE_SOFTWARE_SEL};
            inv_sync_q <= {inv_sync_q[0], SHIFT_CLOCK_INVERT};
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (!RESET_N)
        begin
            pin_signed_sync_q <= '0;
            pin_wide_sync_q <= '0;
            pin_pdown_sync_q <= '0;
            pin_coding_sync_q <= '0;
        end
        else
        begin
            pin_signed_sync_q <= {pin_signed_sync_q[0], RANGE_SIGNED_PIN};
            pin_wide_sync_q <= {pin_wide_sync_q[0], WIDE_RANGE_SEL};
            pin_pdown_sync_q <= {pin_pdown_sync_q[0], POWER_DOWN_PIN};
            pin_coding_sync_q <= {pin_coding_sync_q[0], OUTPUT_CODING_SEL};
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (!RESET_N)
        begin
            cfg_clk_sync_q <= '0;
            cfg_sel_sync_q <= '1;
            cfg_din_sync_q <= '0;
        end
        else
        begin
            cfg_clk_sync_q <= {cfg_clk_sync_q[0], CONFIG_PORT_CLOCK};
            cfg_sel_sync_q <= {cfg_sel_sync_q[0], CONFIG_PORT_SELECT_N};
            cfg_din_sync_q <= {cfg_din_sync_q[0], CONFIG_PORT_DATA_IN};
        end
    end

    assign frame_s = frame_sync_q[SYNC_STAGES-1];
    assign done_s = done_sync_q[SYNC_STAGES-1];
    assign ser_s = ser_sync_q[SYNC_STAGES-1];
    assign ext_s = ext_sync_q[SYNC_STAGES-1];
    assign hwsw_s = hwsw_sync_q[SYNC_STAGES-1];

    // ------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------
    logic slave_mode;
    logic hw_cfg_mode;
    logic cfg_port_en;

    assign slave_mode = ser_s & ext_s;
    assign hw_cfg_mode = ~ser_s | hwsw_s;
    assign cfg_port_en = ser_s & ~hwsw_s;

    // Output pin is driven only inside a read frame in slave serial mode
    assign SERIAL_RESULT_OE = ~frame_idle & slave_mode;
    assign SERIAL_RESULT_OUT = serial_bit;

    // ------------------------------------------------------------------
    // Result word holding: frozen while a frame is open
    // ------------------------------------------------------------------
    logic [RESULT_BITS-1:0] pend_word_q;
    logic pend_q;

    always_ff @(posedge SYS_CLK)
    begin
        if (!RESET_N)
            out_word_q <= '0;
        else if (!frame_s && CONV_RESULT_VALID)
            out_word_q <= CONV_RESULT;
        else if (!frame_s && pend_q)
            out_word_q <= pend_word_q;
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (!RESET_N)
        begin
            pend_q <= 1'b0;
            pend_word_q <= '0;
        end
        else if (frame_s && CONV_RESULT_VALID)
        begin
            pend_q <= 1'b1;
            pend_word_q <= CONV_RESULT;
        end
        else if (!frame_s)
            pend_q <= 1'b0;
    end

    // ------------------------------------------------------------------
    // Read overrun detection
    // ------------------------------------------------------------------
    logic read_open_q;

    // A read of the held word counts as open until all 16 bits are seen
    always_ff @(posedge SYS_CLK)
    begin
        if (!RESET_N)
            read_open_q <= 1'b0;
        else if (frame_s && !done_s && slave_mode)
            read_open_q <= 1'b1;
        else if (done_s || CONV_RESULT_VALID)
            read_open_q <= 1'b0;
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (!RESET_N)
            READ_OVERRUN_FLAG <= 1'b0;
        else
            READ_OVERRUN_FLAG <= CONV_RESULT_VALID & read_open_q & ~done_s;
    end

    // ------------------------------------------------------------------
    // Configuration: serial port word or hardware pins
    // ------------------------------------------------------------------
    logic [CFG_BITS-1:0] cfg_word;

    asr_cfg_port u_cfg_port
    (
        .clk(SYS_CLK),
        .rst_n(RESET_N),
        .port_en(cfg_port_en),
        .clk_inv(inv_sync_q[SYNC_STAGES-1]),
        .cfg_clk_s(cfg_clk_sync_q[SYNC_STAGES-1]),
        .cfg_sel_n_s(cfg_sel_sync_q[SYNC_STAGES-1]),
        .cfg_din_s(cfg_din_sync_q[SYNC_STAGES-1]),
        .cfg_word_q(cfg_word)
    );

    assign CONFIG_WORD = cfg_word;

    // Pins steer only in hardware mode; in software mode they are not read
    always_ff @(posedge SYS_CLK)
    begin
        if (!RESET_N)
        begin
            RANGE_SIGNED <= 1'b0;
            RANGE_WIDE <= 1'b0;
            POWER_DOWN <= 1'b0;
            OFFSET_BINARY <= 1'b0;
        end
        else if (hw_cfg_mode)
        begin
            RANGE_SIGNED <= pin_signed_sync_q[SYNC_STAGES-1];
            RANGE_WIDE <= pin_wide_sync_q[SYNC_STAGES-1];
            POWER_DOWN <= pin_pdown_sync_q[SYNC_STAGES-1];
            OFFSET_BINARY <= pin_coding_sync_q[SYNC_STAGES-1];
        end
        else
        begin
            RANGE_SIGNED <= cfg_word[CFG_POS_SIGNED];
            RANGE_WIDE <= cfg_word[CFG_POS_WIDE];
            POWER_DOWN <= cfg_word[CFG_POS_PDOWN];
            OFFSET_BINARY <= cfg_word[CFG_POS_CODING];
        end
    end
endmodule
`default_nettype wire

// ===== verification/asr_serial_core_asserts.sv
// Concurrent checks on the serial readout and configuration block
`timescale 1ns/10ps
`default_nettype none
module asr_serial_core_asserts
    import asr_pkg::*;
(
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    // Watched inputs
    input wire logic CONV_RESULT_VALID,
    input wire logic CHIP_SELECT_N,
    input wire logic READ_STROBE_N,
    input wire logic SERIAL_PARALLEL_SEL,
    input wire logic HARDWARE_SOFTWARE_SEL,
    input wire logic RANGE_SIGNED_PIN,
    input wire logic CONFIG_PORT_SELECT_N,
    // Watched outputs
    input wire logic SERIAL_RESULT_OE,
    input wire logic READ_OVERRUN_FLAG,
    input wire logic RANGE_SIGNED,
    input wire logic RANGE_WIDE,
    input wire logic POWER_DOWN,
    input wire logic OFFSET_BINARY,
    input wire logic [CFG_BITS-1:0] CONFIG_WORD
);
    default clocking @(posedge SYS_CLK);
    endclocking
    default disable iff (!RESET_N);
    sequence hw_rise;
        $rose(RANGE_SIGNED_PIN) && HARDWARE_SOFTWARE_SEL ##1
            (HARDWARE_SOFTWARE_SEL && RANGE_SIGNED_PIN)[*4];
    endsequence
    sequence sw_steady;
        (SERIAL_PARALLEL_SEL && !HARDWARE_SOFTWARE_SEL)[*6];
    endsequence
    a_oe_in_frame: assert property (SERIAL_RESULT_OE |-> !CHIP_SELECT_N && !READ_STROBE_N)
        else $error("output enabled outside a read frame");
    a_oe_serial_only: assert property (SERIAL_RESULT_OE |->
        $past(SERIAL_PARALLEL_SEL, 2) || $past(SERIAL_PARALLEL_SEL, 3))
        else $error("output enabled in parallel mode");
    a_overrun_cause: assert property (READ_OVERRUN_FLAG |-> $past(CONV_RESULT_VALID))
        else $error("overrun flag without conversion end");
    a_overrun_pulse: assert property (READ_OVERRUN_FLAG |=> !READ_OVERRUN_FLAG)
        else $error("overrun flag longer than one cycle");
    a_reset_clears: assert property (disable iff (1'b0) !RESET_N |=> CONFIG_WORD == 9'h000 &&
        !(RANGE_SIGNED || RANGE_WIDE || POWER_DOWN || OFFSET_BINARY || READ_OVERRUN_FLAG))
        else $error("configuration not cleared by reset");
    a_cfg_needs_port: assert property ($changed(CONFIG_WORD) |-> !$past(CONFIG_PORT_SELECT_N, 3) &&
        !$past(HARDWARE_SOFTWARE_SEL, 3) && $past(SERIAL_PARALLEL_SEL, 3))
        else $error("configuration changed without an enabled port");
    a_start_kept: assert property ($changed(CONFIG_WORD) |-> CONFIG_WORD[CFG_POS_START])
        else $error("word applied without start bit");
    a_reserved_zero: assert property (CONFIG_WORD[4:3] == 2'b00 && CONFIG_WORD[1:0] == 2'b00)
        else $error("reserved position written");
    a_pins_follow: assert property (hw_rise |-> RANGE_SIGNED)
        else $error("range pin not applied in hardware mode");
    a_sw_uses_word: assert property (sw_steady |->
        {RANGE_SIGNED, RANGE_WIDE, POWER_DOWN, OFFSET_BINARY} == {$past(CONFIG_WORD[7:5]),
        $past(CONFIG_WORD[2])})
        else $error("software mode output not from configuration word");
endmodule
bind asr_serial_core asr_serial_core_asserts u_asr_chk (
    .SYS_CLK, .RESET_N, .CONV_RESULT_VALID, .CHIP_SELECT_N, .READ_STROBE_N,
    .SERIAL_PARALLEL_SEL, .HARDWARE_SOFTWARE_SEL, .RANGE_SIGNED_PIN, .CONFIG_PORT_SELECT_N,
    .SERIAL_RESULT_OE, .READ_OVERRUN_FLAG, .RANGE_SIGNED, .RANGE_WIDE, .POWER_DOWN,
    .OFFSET_BINARY, .CONFIG_WORD
);
`default_nettype wire

// ===== verification/asr_host_model.sv
// Host model driving the slave serial result link
`timescale 1ns/10ps
`default_nettype none
module asr_host_model (
    // Link pins driven by the host
    output logic sclk,
    output logic cs_n,
    output logic rd_n,
    output logic chain_in,
    // Result line from the device
    input wire logic sdo
);
    // Clock stands still between frames
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        rd_n = 1'b1;
        chain_in = 1'b0;
    end
    task automatic open_frame();
        #17;
        cs_n = 1'b0;
        rd_n = 1'b0;
        #200;
    endtask
    // 80 ns period leaves a half period for delay plus setup
    task automatic shift(input int n, input logic [15:0] up, output logic [31:0] got);
        got = '0;
        for (int i = 0; i < n; i++)
        begin
            got = {got[30:0], sdo};
            #40 sclk = 1'b1;
            // Upstream data moves just after the launch edge, as a chained device would
            #1 chain_in = up[15 - (i % 16)];
            #39 sclk = 1'b0;
        end
        #1 chain_in = 1'b0;
    endtask
    task automatic close_frame();
        #40;
        cs_n = 1'b1;
        rd_n = 1'b1;
        #200;
    endtask
endmodule
`default_nettype wire

// ===== verification/test_adc_serial_slave_readout_and_config.sv
// Self-checking bench for the serial readout and configuration block
`timescale 1ns/10ps
`default_nettype none
module test_adc_serial_slave_readout_and_config
    import asr_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic busy = 1'b0;
    logic valid = 1'b0;
    logic [RESULT_BITS-1:0] result = 16'h0000;
    logic sp_sel = 1'b1;
    logic hs_sel = 1'b0;
    logic [3:0] pins = 4'h0;
    logic cclk = 1'b0;
    logic csel_n = 1'b1;
    logic cdin = 1'b0;
    logic inv = 1'b0;
    logic ext = 1'b1;
    wire logic sclk, cs_n, rd_n, chain, sdo, oe, ovr;
    wire logic [3:0] outs;
    wire logic [CFG_BITS-1:0] cfg;
    int miscompares = 0;
    int comparisons = 0;
    logic [31:0] got;
    logic seen;
    asr_serial_core uut (
        .SYS_CLK(clk), .RESET_N(rst_n), .CONV_BUSY(busy), .CONV_RESULT_VALID(valid),
        .CONV_RESULT(result), .SERIAL_SHIFT_CLOCK(sclk), .CHIP_SELECT_N(cs_n),
        .READ_STROBE_N(rd_n), .CHAIN_SERIAL_INPUT(chain), .SHIFT_CLOCK_INVERT(inv),
        .SERIAL_RESULT_OUT(sdo), .SERIAL_RESULT_OE(oe), .READ_OVERRUN_FLAG(ovr),
        .SERIAL_PARALLEL_SEL(sp_sel), .CLOCK_SOURCE_SEL(ext),
        .HARDWARE_SOFTWARE_SEL(hs_sel), .RANGE_SIGNED_PIN(pins[3]), .WIDE_RANGE_SEL(pins[2]),
        .POWER_DOWN_PIN(pins[1]), .OUTPUT_CODING_SEL(pins[0]), .CONFIG_PORT_CLOCK(cclk),
        .CONFIG_PORT_SELECT_N(csel_n), .CONFIG_PORT_DATA_IN(cdin), .RANGE_SIGNED(outs[3]),
        .RANGE_WIDE(outs[2]), .POWER_DOWN(outs[1]), .OFFSET_BINARY(outs[0]), .CONFIG_WORD(cfg)
    );
    asr_host_model u_host (.sclk(sclk), .cs_n(cs_n), .rd_n(rd_n), .chain_in(chain), .sdo(sdo));
    initial
    begin
        forever #20 clk = ~clk;
    end
    task automatic check(input logic [31:0] g, input logic [31:0] e, input string what);
        comparisons++;
        if (g !== e)
        begin
            miscompares++;
            $display("BAD %0t %s got %h expected %h", $time, what, g, e);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Conversion end pulse, then watch the overrun flag for a few cycles
    task automatic pulse(input logic [15:0] res, output logic f);
        @(posedge clk);
        result <= res;
        valid <= 1'b1;
        busy <= 1'b0;
        f = 1'b0;
        repeat (6)
        begin
            @(posedge clk);
            valid <= 1'b0;
            #1 f = f | ovr;
        end
    endtask
    task automatic cfg_write(input logic [8:0] w, input int n);
        @(posedge clk);
        csel_n <= 1'b0;
        for (int i = 0; i < n; i++)
        begin
            tick(4);
            cdin <= w[8 - i];
            tick(4);
            cclk <= 1'b1;
            tick(4);
            cclk <= 1'b0;
        end
        tick(4);
        csel_n <= 1'b1;
        tick(8);
    endtask
    task automatic read_after_chain();
        pulse(16'ha5c3, seen);
        check(seen, 1'b0, "flag without read");
        u_host.open_frame();
        check({oe, sdo}, 2'b11, "frame open with MSB");
        u_host.shift(32, 16'h3c96, got);
        u_host.close_frame();
        check(got, 32'ha5c3_3c96, "chained read");
    endtask
    task automatic read_during_overrun();
        pulse(16'h1234, seen);
        u_host.open_frame();
        @(posedge clk);
        busy <= 1'b1;
        u_host.shift(5, 16'h0000, got);
        check(got, 32'h02, "partial read");
        pulse(16'hbeef, seen);
        check(seen, 1'b1, "overrun flag");
        u_host.close_frame();
        u_host.open_frame();
        u_host.shift(16, 16'h0000, got);
        u_host.close_frame();
        check(got, 32'hbeef, "pended result");
        pulse(16'h5a5a, seen);
        check(seen, 1'b0, "flag after full read");
    endtask
    task automatic cfg_ranges();
        logic [8:0] w;
        for (int r = 0; r < 4; r++)
        begin
            w = {1'b1, r[1:0], r[0], 2'b11, r[1], 2'b11};
            // Upper two words are taken on the falling port clock edge
            @(posedge clk);
            inv <= r[1];
            cfg_write(w, 9);
            check(cfg, {w[8:5], 2'b00, w[2], 2'b00}, "applied word");
            check(outs, {w[7:5], w[2]}, "applied settings");
        end
        inv <= 1'b0;
    endtask
    task automatic cfg_refused();
        cfg_write(9'h000, 9);
        check(cfg, 9'h1e4, "start bit low");
        cfg_write(9'h100, 5);
        check(cfg, 9'h1e4, "partial word");
        hs_sel <= 1'b1;
        pins <= 4'b1010;
        tick(6);
        cfg_write(9'h100, 9);
        check(cfg, 9'h1e4, "port in hardware mode");
        check(outs, 4'b1010, "pins in hardware mode");
    endtask
    task automatic mode_pins();
        ext <= 1'b0;
        tick(4);
        u_host.open_frame();
        check(oe, 1'b0, "serial output with internal clock");
        u_host.close_frame();
        @(posedge clk);
        ext <= 1'b1;
        sp_sel <= 1'b0;
        pins <= 4'b0101;
        tick(6);
        check(outs, 4'b0101, "pins in parallel mode");
        u_host.open_frame();
        check(oe, 1'b0, "serial output in parallel mode");
        u_host.close_frame();
        @(posedge clk);
        sp_sel <= 1'b1;
        hs_sel <= 1'b0;
        pins <= 4'b1010;
        tick(6);
        check(outs, 4'b1111, "pins in software mode");
    endtask
    task automatic mid_reset();
        rst_n <= 1'b0;
        tick(3);
        rst_n <= 1'b1;
        check({cfg, outs, ovr}, 14'h0000, "second reset");
        tick(4);
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        tick(20);
        rst_n <= 1'b1;
        check({cfg, outs, ovr}, 14'h0000, "first reset");
        tick(4);
        read_after_chain();
        read_during_overrun();
        cfg_ranges();
        cfg_refused();
        mode_pins();
        mid_reset();
        report_and_stop();
    end
    initial
    begin
        #2000000;
        miscompares++;
        report_and_stop();
    end
endmodule
`default_nettype wire
